// [rtl/rsi_supervisor.sv]
/*
 * status and supervisory logic: irq/out pin, battery low, write
 * deselect time, serial number, oscillator fail, power-up defaults.
 * assumes a byte register port from the serial bus engine, and analog
 * levels (supply good, battery ok, oscillator running) from pins.
 */
`timescale 1ns/1ns
`default_nettype none
`include "rsi_map.svh"
module rsi_supervisor
	import rsi_pkg::*;
#(
	parameter logic [63:0] BAT_CYC = `RSI_BAT_CYC,
	parameter logic [31:0] TREC_LONG = `RSI_TREC_LONG_CYC,
	parameter logic [31:0] TREC_STOP = `RSI_TREC_STOP_CYC,
	parameter logic [31:0] TREC_SHORT = `RSI_TREC_SHORT_CYC
) (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic first_power_i,
	input wire logic supply_good_i,
	input wire logic battery_ok_i,
	input wire logic osc_running_i,
	input wire logic reset_out_i,
	input wire logic tamper_enable_one_i,
	input wire logic tamper_enable_two_i,
	input wire logic tamper_irq_enable_i,
	input wire logic alarm_irq_i,
	input wire logic watchdog_irq_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic write_allow_o,
	output logic irq_out_oe_o,
	output logic oscillator_stop_bit_o,
	output logic halt_update_bit_o,
	output logic frequency_test_bit_o,
	output logic square_wave_enable_o,
	output logic full_time_clock_out_enable_o,
	output logic threshold_select_o,
	output logic tamper_irq_clear_o
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		rsi_sync_t sy;
		rsi_pwr_t pwr;
		logic [31:0] desel_cnt;
		logic [63:0] bat_cnt;
		logic bat_pend;
		logic battery_low_flag;
		logic osc_fail_flag;
		logic osc_fail_irq_enable;
		logic alarm_flag_enable;
		logic backup_alarm_enable;
		logic deselect_time_select;
		logic oscillator_stop_bit;
		logic halt_update_bit;
		logic out_bit;
		logic frequency_test_bit;
		logic square_wave_enable;
		logic full_time_clock_out_enable;
		logic threshold_select;
		logic watchdog_steering;
		logic [7:0] rdata;
		logic rd_serial;
	} rsi_state_t;

	rsi_state_t q;
	rsi_state_t next_q;
	logic [7:0] ser_data;
	logic supply;
	logic bat_ok;
	logic osc_run;
	logic first_pw;
	logic rst_out;
	logic irq_src;
	logic irq_low;
	logic wr_ok;

	function automatic logic [31:0] rsi_trec(input logic sel, input logic stop);
		if (sel)
			rsi_trec = TREC_SHORT;
		else if (stop)
			rsi_trec = TREC_STOP;
		else
			rsi_trec = TREC_LONG;
	endfunction : rsi_trec

	rsi_serial_rom u_rom (
		.mclk_i(mclk_i),
		.idx_i(reg_addr_i[2:0] - 3'(`RSI_OFF_SERIAL)),
		.data_o(ser_data)
	);

	// second stage only; first stage is read by nothing else
	assign supply = q.sy.s_sync[1];
	assign bat_ok = q.sy.b_sync[1];
	assign osc_run = q.sy.o_sync[1];
	assign first_pw = q.sy.v_sync[1];
	assign rst_out = q.sy.r_sync[1];
	assign wr_ok = (q.pwr == RSI_RUN);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_q = q;
		next_q.sy.s_sync = {q.sy.s_sync[0], supply_good_i};
		next_q.sy.v_sync = {q.sy.v_sync[0], first_power_i};
		next_q.sy.b_sync = {q.sy.b_sync[0], battery_ok_i};
		next_q.sy.o_sync = {q.sy.o_sync[0], osc_running_i};
		next_q.sy.r_sync = {q.sy.r_sync[0], reset_out_i};
		next_q.rd_serial = 1'b0;
		if (first_pw) begin
			// initial power-up defaults
			next_q.osc_fail_flag = `RSI_INIT_OSC_FAIL;
			next_q.halt_update_bit = `RSI_INIT_HALT;
			next_q.out_bit = `RSI_INIT_OUT;
			next_q.full_time_clock_out_enable = `RSI_INIT_32K;
			next_q.deselect_time_select = 1'b0;
			next_q.oscillator_stop_bit = 1'b0;
			next_q.osc_fail_irq_enable = 1'b0;
			next_q.frequency_test_bit = 1'b0;
			next_q.alarm_flag_enable = 1'b0;
			next_q.backup_alarm_enable = 1'b0;
			next_q.square_wave_enable = 1'b0;
			next_q.threshold_select = 1'b0;
			next_q.watchdog_steering = 1'b0;
		end
		case (q.pwr)
			RSI_OFF: begin
				if (supply) begin
					// rising supply: clear enables, all but full_time_clock_out_enable
					next_q.osc_fail_irq_enable = 1'b0;
					next_q.alarm_flag_enable = 1'b0;
					next_q.backup_alarm_enable = 1'b0;
					next_q.square_wave_enable = 1'b0;
					next_q.watchdog_steering = 1'b0;
					next_q.frequency_test_bit = 1'b0;
					next_q.desel_cnt = rsi_trec(q.deselect_time_select,
						q.oscillator_stop_bit);
					next_q.bat_pend = 1'b1; // check at power-up
					next_q.pwr = RSI_DESEL;
				end
			end
			RSI_DESEL: begin
				// writes held off while the supply settles
				if (!supply)
					next_q.pwr = RSI_OFF;
				else if (q.desel_cnt <= 32'h1)
					next_q.pwr = RSI_RUN;
				else
					next_q.desel_cnt = q.desel_cnt - 32'h1;
			end
			RSI_RUN: begin
				if (!supply) begin
					// falling supply
					next_q.frequency_test_bit = 1'b0;
					next_q.halt_update_bit = !(tamper_enable_one_i || tamper_enable_two_i);
					next_q.pwr = RSI_OFF;
				end
			end
			default: next_q.pwr = RSI_OFF;
		endcase
		// battery check only on main supply
		if (supply) begin
			if (q.bat_cnt >= BAT_CYC - 64'h1) begin
				next_q.bat_cnt = 64'h0;
				next_q.bat_pend = 1'b1; // periodic
			end else begin
				next_q.bat_cnt = q.bat_cnt + 64'h1;
			end
			if (q.bat_pend) begin
				next_q.bat_pend = 1'b0;
				next_q.battery_low_flag = !bat_ok;
			end
		end
		if (reg_wr_i && wr_ok) begin
			case (reg_addr_i)
				`RSI_OFF_CLOCK: next_q.deselect_time_select = reg_wdata_i[`RSI_BIT_DESEL_SEL];
				`RSI_OFF_FLAGS: if (!reg_wdata_i[`RSI_BIT_OSC_FAIL])
					next_q.osc_fail_flag = 1'b0; // only a zero clears
				8'h01: begin
					next_q.oscillator_stop_bit = reg_wdata_i[7];
				end
				8'h02: begin
					next_q.out_bit = reg_wdata_i[7];
					next_q.frequency_test_bit = reg_wdata_i[6];
					next_q.halt_update_bit = reg_wdata_i[5];
					next_q.threshold_select = reg_wdata_i[4];
					next_q.full_time_clock_out_enable = reg_wdata_i[3];
					next_q.square_wave_enable = reg_wdata_i[2];
					next_q.watchdog_steering = reg_wdata_i[1];
				end
				8'h03: begin
					next_q.osc_fail_irq_enable = reg_wdata_i[7];
					next_q.alarm_flag_enable = reg_wdata_i[6];
					next_q.backup_alarm_enable = reg_wdata_i[5];
				end
				default: ; // serial number and others ignore writes
			endcase
		end
		// stop detection set wins over a clear, in backup too
		if (!osc_run || q.oscillator_stop_bit)
			next_q.osc_fail_flag = 1'b1;
		if (reg_rd_i) begin
			next_q.rd_serial = (reg_addr_i[7:3] == 5'(`RSI_OFF_SERIAL >> 3));
			case (reg_addr_i)
				`RSI_OFF_CLOCK: next_q.rdata = {q.deselect_time_select, 7'h00};
				`RSI_OFF_FLAGS: next_q.rdata = {3'h0, q.battery_low_flag, 1'b0,
					q.osc_fail_flag, 2'h0};
				8'h01: next_q.rdata = {q.oscillator_stop_bit, 7'h00};
				8'h02: next_q.rdata = {q.out_bit, q.frequency_test_bit,
					q.halt_update_bit, q.threshold_select,
					q.full_time_clock_out_enable, q.square_wave_enable,
					q.watchdog_steering, 1'b0};
				8'h03: next_q.rdata = {q.osc_fail_irq_enable, q.alarm_flag_enable,
					q.backup_alarm_enable, 5'h00};
				default: next_q.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			q <= '0;
			q.pwr <= RSI_OFF;
		end else begin
			q <= next_q;
		end
	end

	// ----------------------------------------------------------------
	// irq/out pin
	// ----------------------------------------------------------------
	// fail irq released by flag clear, enable clear or reset out
	assign irq_src = (q.osc_fail_irq_enable && q.osc_fail_flag && !rst_out)
		|| (q.alarm_flag_enable && alarm_irq_i) || watchdog_irq_i;
	always_comb begin
		if (q.osc_fail_irq_enable || q.alarm_flag_enable || tamper_irq_enable_i
			|| q.watchdog_steering)
			irq_low = irq_src;
		else
			irq_low = !q.out_bit;
		if (!supply && !q.backup_alarm_enable)
			irq_low = 1'b0; // backup needs backup alarm enable
	end

	assign irq_out_oe_o = irq_low;
	assign reg_rdata_o = q.rd_serial ? ser_data : q.rdata;
	assign write_allow_o = wr_ok;
	assign oscillator_stop_bit_o = q.oscillator_stop_bit;
	assign halt_update_bit_o = q.halt_update_bit;
	assign frequency_test_bit_o = q.frequency_test_bit;
	assign square_wave_enable_o = q.square_wave_enable;
	assign full_time_clock_out_enable_o = q.full_time_clock_out_enable;
	assign threshold_select_o = q.threshold_select;
	assign tamper_irq_clear_o = (q.pwr == RSI_OFF) && supply;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	osc_flag_set_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		!osc_run |=> q.osc_fail_flag) else $error("fail flag not set");
	osc_flag_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		q.osc_fail_flag && !(reg_wr_i && reg_addr_i == `RSI_OFF_FLAGS) |=> q.osc_fail_flag)
		else $error("fail flag dropped");
	irq_fail_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		q.osc_fail_irq_enable && q.osc_fail_flag && !rst_out && supply |-> irq_out_oe_o)
		else $error("fail irq missing");
	irq_out_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		!q.osc_fail_irq_enable && !q.alarm_flag_enable && !tamper_irq_enable_i
		&& !q.watchdog_steering && supply |-> irq_out_oe_o == !q.out_bit)
		else $error("out bit not on pin");
	irq_backup_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		!supply && !q.backup_alarm_enable |-> !irq_out_oe_o)
		else $error("pin driven in backup");
	desel_block_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		$rose(supply) |=> !write_allow_o [*3]) else $error("write too early");
	bat_check_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		q.bat_pend && supply |=> q.battery_low_flag == !$past(bat_ok))
		else $error("battery flag wrong");
	bat_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		!supply |=> $stable(q.battery_low_flag)) else $error("check in backup");
	serial_ro_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		reg_wr_i && reg_addr_i[7:3] == 5'h06 |=> $stable(q.out_bit))
		else $error("serial write had effect");
endmodule : rsi_supervisor
`default_nettype wire

// [inc/rsi_map.svh]
/*
 * register offsets, field positions, power-up values and timing counts
 * of the status and supervisory block; included by the design files.
 */
`ifndef RSI_MAP_SVH
`define RSI_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RSI_OFF_CLOCK 8'h04
`define RSI_OFF_FLAGS 8'h0f
`define RSI_OFF_SERIAL 8'h30
`define RSI_SERIAL_BYTES 8
// arbitrary value, stands in for the per-part number
`define RSI_SERIAL_VALUE 64'h5a3c_9612_e0f1_7b80

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RSI_BIT_DESEL_SEL 7
`define RSI_BIT_OSC_FAIL 2
`define RSI_BIT_BAT_LOW 4

// ----------------------------------------------------------------
// power-up values of control bits
// ----------------------------------------------------------------
`define RSI_INIT_OSC_FAIL 1'b1
`define RSI_INIT_HALT 1'b1
`define RSI_INIT_OUT 1'b1
`define RSI_INIT_32K 1'b1

// ----------------------------------------------------------------
// timing: clock 50 MHz
// ----------------------------------------------------------------
`define RSI_CLK_HZ 50000000
`define RSI_TREC_LONG_MS 97
`define RSI_TREC_STOP_MS 100
`define RSI_TREC_SHORT_US 50
`define RSI_TREC_LONG_CYC (`RSI_CLK_HZ / 1000 * `RSI_TREC_LONG_MS)
`define RSI_TREC_STOP_CYC (`RSI_CLK_HZ / 1000 * `RSI_TREC_STOP_MS)
`define RSI_TREC_SHORT_CYC (`RSI_CLK_HZ / 1000000 * `RSI_TREC_SHORT_US)
`define RSI_BAT_HOURS 24
`define RSI_BAT_CYC (64'd3600 * `RSI_BAT_HOURS * `RSI_CLK_HZ)

`endif

// [inc/rsi_pkg.sv]
/*
 * types of the status and supervisory block.
 * assumes nothing of its surroundings.
 */
package rsi_pkg;
	typedef enum logic [1:0] {
		RSI_OFF = 2'b00,
		RSI_DESEL = 2'b01,
		RSI_RUN = 2'b10
	} rsi_pwr_t;

	typedef struct packed {
		logic [1:0] s_sync;
		logic [1:0] v_sync;
		logic [1:0] b_sync;
		logic [1:0] o_sync;
		logic [1:0] r_sync;
	} rsi_sync_t;
endpackage : rsi_pkg

// [rtl/rsi_serial_rom.sv]
/*
 * read-only serial number store, eight bytes, registered read data.
 * assumes the index is in range; the three index bits cover exactly the eight bytes.
 */
`timescale 1ns/1ns
`default_nettype none
`include "rsi_map.svh"
module rsi_serial_rom #(
	parameter logic [63:0] SERIAL = `RSI_SERIAL_VALUE // arbitrary value
) (
	input wire logic mclk_i,
	input wire logic [2:0] idx_i,
	output logic [7:0] data_o
);
	always_ff @(posedge mclk_i) begin
		data_o <= SERIAL[idx_i*8 +: 8];
	end
endmodule : rsi_serial_rom
`default_nettype wire

// [verif/rsi_host.sv]
/* host model: byte register port master, irq line with pull-up.
   assumes the device answers reads one cycle after the strobe. */
`timescale 1ns/1ns
`default_nettype none
module rsi_host #(
	parameter int RUN_MIN = 40
) (
	input wire logic mclk_i,
	input wire logic osc_running_i,
	input wire logic irq_out_oe_i,
	input wire logic [7:0] reg_rdata_i,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [7:0] reg_addr_o,
	output logic [7:0] reg_wdata_o,
	output logic irq_n_o
);
	int run_cnt = 0;
	initial begin
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
	end
	// open drain: pull-up wins unless the device sinks
	assign irq_n_o = irq_out_oe_i ? 1'b0 : 1'b1;
	always @(posedge mclk_i) begin
		run_cnt <= osc_running_i ? run_cnt + 1 : 0;
	end
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] dt);
		@(posedge mclk_i);
		reg_wr_o <= wr;
		reg_rd_o <= !wr;
		reg_addr_o <= a;
		reg_wdata_o <= dt;
		@(posedge mclk_i);
		reg_wr_o <= 1'b0;
		reg_rd_o <= 1'b0;
		// released lines carry no stale value
		reg_addr_o <= ~a;
		reg_wdata_o <= ~dt;
	endtask : xfer
	task automatic rd(input logic [7:0] a, output logic [7:0] dt);
		xfer(1'b0, a, 8'h00);
		@(posedge mclk_i);
		dt = reg_rdata_i;
	endtask : rd
	// fail flag only cleared once the oscillator has run long enough
	task automatic clr_fail();
		while (run_cnt < RUN_MIN) @(posedge mclk_i);
		xfer(1'b1, 8'h0f, 8'h00);
	endtask : clr_fail
endmodule : rsi_host
`default_nettype wire

// [verif/rsi_supervisor_test.sv]
/* self-checking bench of the supervisor, host model on its port.
   assumes the package and the map header are compiled first. */
`timescale 1ns/1ns
`default_nettype none
`include "rsi_map.svh"
module rsi_supervisor_test;
	import rsi_pkg::*;
	// ----------------------------------------------------------------
	// setup: short counts keep the run brief
	// ----------------------------------------------------------------
	localparam int TL = 20;
	localparam int TS = 30;
	localparam int TH = 5;
	localparam int BC = 100;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic first_power_i = 1'b0;
	logic supply_good_i = 1'b0;
	logic battery_ok_i = 1'b0;
	logic osc_running_i = 1'b1;
	logic reset_out_i = 1'b0;
	logic tamper_enable_one_i = 1'b0;
	logic tamper_enable_two_i = 1'b0;
	logic tamper_irq_enable_i = 1'b0;
	logic alarm_irq_i = 1'b0;
	logic watchdog_irq_i = 1'b0;
	logic reg_wr_i, reg_rd_i, write_allow_o, irq_out_oe_o, irq_n;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d, s0;
	logic oscillator_stop_bit_o, halt_update_bit_o, frequency_test_bit_o;
	logic square_wave_enable_o, full_time_clock_out_enable_o, threshold_select_o;
	logic tamper_irq_clear_o;
	int failures = 0;
	int num_checks = 0;
	int tcnt = 0;
	int n;
	int t0;
	initial forever #10 mclk_i = ~mclk_i;
	always @(posedge mclk_i) if (tamper_irq_clear_o === 1'b1) tcnt++;
	rsi_supervisor #(.BAT_CYC(BC), .TREC_LONG(TL), .TREC_STOP(TS), .TREC_SHORT(TH)) i_dut (
		.mclk_i, .rst_i, .first_power_i, .supply_good_i, .battery_ok_i, .osc_running_i,
		.reset_out_i, .tamper_enable_one_i, .tamper_enable_two_i, .tamper_irq_enable_i,
		.alarm_irq_i, .watchdog_irq_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
		.reg_rdata_o, .write_allow_o, .irq_out_oe_o, .oscillator_stop_bit_o,
		.halt_update_bit_o, .frequency_test_bit_o, .square_wave_enable_o,
		.full_time_clock_out_enable_o, .threshold_select_o, .tamper_irq_clear_o);
	rsi_host i_host (.mclk_i, .osc_running_i, .irq_out_oe_i(irq_out_oe_o),
		.reg_rdata_i(reg_rdata_o), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
		.reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .irq_n_o(irq_n));
	// ----------------------------------------------------------------
	// expectations and checks
	// ----------------------------------------------------------------
	function automatic int trec(input logic sel, input logic stop);
		return sel ? TH : (stop ? TS : TL);
	endfunction : trec
	function automatic logic exp_pin(input logic out, input logic src, input logic bkp,
		input logic abe);
		if (bkp && !abe) return 1'b1;
		return src ? 1'b0 : out;
	endfunction : exp_pin
	task automatic results();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] e);
		i_host.rd(a, d);
		chk(nm, e, d & m);
	endtask : rdc
	task automatic pin(input logic e);
		@(negedge mclk_i);
		chk("pin", {7'h0, e}, {7'h0, irq_n});
	endtask : pin
	task automatic pwr(input logic up, input logic sel, input logic stop);
		@(posedge mclk_i);
		supply_good_i <= up;
		n = 0;
		while (up && write_allow_o !== 1'b1 && n < 1000) begin
			@(posedge mclk_i);
			n++;
		end
		repeat (6) @(posedge mclk_i);
		if (up) chk("desel", 8'h01, {7'h0, n >= trec(sel, stop) && n <= trec(sel, stop) + 6});
	endtask : pwr
	initial begin
		#(20 * 20000);
		failures++;
		results();
	end
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(870));
		repeat (12) @(posedge mclk_i);
		rst_i <= 1'b0;
		first_power_i <= 1'b1;
		repeat (5) @(posedge mclk_i);
		first_power_i <= 1'b0;
		fork
			pwr(1'b1, 1'b0, 1'b0);
			i_host.xfer(1'b1, 8'h02, 8'h00);
		join
		rdc("flags", 8'h0f, 8'h14, 8'h14);
		rdc("ctl", 8'h02, 8'hfc, 8'ha8);
		rdc("ena", 8'h03, 8'he0, 8'h00);
		rdc("stop", 8'h01, 8'h80, 8'h00);
		rdc("tsel", 8'h04, 8'h80, 8'h00);
		@(negedge mclk_i);
		chk("outs", 8'h24, {2'h0, halt_update_bit_o, frequency_test_bit_o, square_wave_enable_o,
			full_time_clock_out_enable_o, threshold_select_o, oscillator_stop_bit_o});
		pin(1'b1);
		@(posedge mclk_i);
		battery_ok_i <= 1'b1;
		rdc("batlow_hold", 8'h0f, 8'h10, 8'h10);
		repeat (BC + 5) @(posedge mclk_i);
		rdc("batlow_pass", 8'h0f, 8'h10, 8'h00);
		for (int i = 0; i < 6; i++) begin
			d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
			i_host.xfer(1'b1, 8'h02, d);
			// steering bit puts the pin in irq mode, no source: released
			pin(d[1] ? 1'b1 : exp_pin(d[7], 1'b0, 1'b0, 1'b0));
		end
		for (int i = 0; i < 8; i++) begin
			s0 = 8'(`RSI_SERIAL_VALUE >> (8 * i));
			rdc("serial", 8'h30 + 8'(i), 8'hff, s0);
			i_host.xfer(1'b1, 8'h30 + 8'(i), ~s0);
			rdc("serial_wr", 8'h30 + 8'(i), 8'hff, s0);
		end
		i_host.xfer(1'b1, 8'h02, 8'h88);
		i_host.xfer(1'b1, 8'h03, 8'h80);
		pin(exp_pin(1'b1, 1'b1, 1'b0, 1'b0));
		rdc("fail_set", 8'h0f, 8'h04, 8'h04);
		pin(1'b0);
		i_host.clr_fail();
		pin(1'b1);
		@(posedge mclk_i);
		osc_running_i <= 1'b0;
		repeat (5) @(posedge mclk_i);
		i_host.xfer(1'b1, 8'h0f, 8'h00);
		rdc("fail_stop", 8'h0f, 8'h04, 8'h04);
		pin(1'b0);
		i_host.xfer(1'b1, 8'h03, 8'h00);
		pin(1'b1);
		i_host.xfer(1'b1, 8'h03, 8'h80);
		@(posedge mclk_i);
		osc_running_i <= 1'b1;
		reset_out_i <= 1'b1;
		repeat (5) @(posedge mclk_i);
		pin(1'b1);
		@(posedge mclk_i);
		reset_out_i <= 1'b0;
		i_host.clr_fail();
		i_host.xfer(1'b1, 8'h01, 8'h80);
		repeat (5) @(posedge mclk_i);
		rdc("fail_stopbit", 8'h0f, 8'h04, 8'h04);
		chk("stop_out", 8'h01, {7'h0, oscillator_stop_bit_o});
		// backup with tamper armed: halt bit must be cleared
		i_host.xfer(1'b1, 8'h03, 8'he0);
		i_host.xfer(1'b1, 8'h02, 8'h64);
		@(posedge mclk_i);
		tamper_enable_one_i <= 1'b1;
		pwr(1'b0, 1'b0, 1'b0);
		// battery drops only once the supply is gone, so no check may see it before the supply returns
		battery_ok_i <= 1'b0;
		pin(exp_pin(1'b0, 1'b1, 1'b1, 1'b1));
		chk("down", 8'h00, {6'h0, halt_update_bit_o, frequency_test_bit_o});
		repeat (BC + 10) @(posedge mclk_i);
		rdc("batlow_bkp", 8'h0f, 8'h10, 8'h00);
		t0 = tcnt;
		pwr(1'b1, 1'b0, 1'b1);
		chk("tclr", 8'h01, {7'h0, tcnt == t0 + 1});
		rdc("up_ena", 8'h03, 8'he0, 8'h00);
		rdc("up_ctl", 8'h02, 8'hfc, 8'h00);
		rdc("batlow_up", 8'h0f, 8'h10, 8'h10);
		@(posedge mclk_i);
		tamper_enable_one_i <= 1'b0;
		i_host.xfer(1'b1, 8'h01, 8'h00);
		i_host.xfer(1'b1, 8'h04, 8'h80);
		i_host.clr_fail();
		i_host.xfer(1'b1, 8'h03, 8'h80);
		pwr(1'b0, 1'b1, 1'b0);
		pin(exp_pin(1'b0, 1'b0, 1'b1, 1'b0));
		@(posedge mclk_i);
		osc_running_i <= 1'b0;
		repeat (6) @(posedge mclk_i);
		osc_running_i <= 1'b1;
		pwr(1'b1, 1'b1, 1'b0);
		rdc("fail_bkp", 8'h0f, 8'h04, 8'h04);
		results();
	end
endmodule : rsi_supervisor_test
`default_nettype wire
